/* File: rtl/acr_cfg.svh */
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// ********************
// serial frame layout
// ********************
`define ACR_FRAME_BITS 24
`define ACR_ADDR_BITS 8
`define ACR_DATA_BITS 16
`define ACR_ADDR_LSB 16
`define ACR_CNT_ADDR_LAST 5'h07
`define ACR_CNT_READ_LOAD 5'h08
`define ACR_CNT_FRAME_LAST 5'h17
`define ACR_CNT_ZERO 5'h00
`define ACR_RESET_WORD 16'h0000

// ********************
// register addresses
// ********************
`define ACR_ADDR_SOFT_RESET 8'h00
`define ACR_ADDR_READBACK 8'h01
`define ACR_ADDR_SYNC 8'h02
`define ACR_ADDR_RAMP 8'h0A
`define ACR_ADDR_POWER 8'h0F
`define ACR_ADDR_NOISE 8'h14
`define ACR_ADDR_FRAME 8'h1C
`define ACR_ADDR_SEED_LO 8'h23
`define ACR_ADDR_INV_SEED 8'h24
`define ACR_ADDR_TEST 8'h25
`define ACR_ADDR_CODE1 8'h26
`define ACR_ADDR_CODE2 8'h27
`define ACR_ADDR_ORDER 8'h28
`define ACR_ADDR_FILTER 8'h29
`define ACR_ADDR_GAIN 8'h2A
`define ACR_ADDR_UPPER 8'hF0

// ********************
// writable bits per register
// ********************
`define ACR_MASK_READBACK 16'h0011
`define ACR_MASK_SYNC 16'h2000
`define ACR_MASK_FULL 16'hFFFF
`define ACR_MASK_POWER 16'h07FF
`define ACR_MASK_NOISE 16'h00FF
`define ACR_MASK_FRAME 16'h7FFF
`define ACR_MASK_INV_SEED 16'hFEFF
`define ACR_MASK_TEST 16'hF17F
`define ACR_MASK_CODE 16'hFFF0
`define ACR_MASK_ORDER 16'h81FF
`define ACR_MASK_FILTER 16'h0003

// ********************
// storage slots
// ********************
`define ACR_NUM_SLOTS 15
`define ACR_SLOT_READBACK 0
`define ACR_SLOT_SYNC 1
`define ACR_SLOT_RAMP 2
`define ACR_SLOT_POWER 3
`define ACR_SLOT_NOISE 4
`define ACR_SLOT_FRAME 5
`define ACR_SLOT_SEED_LO 6
`define ACR_SLOT_INV_SEED 7
`define ACR_SLOT_TEST 8
`define ACR_SLOT_CODE1 9
`define ACR_SLOT_CODE2 10
`define ACR_SLOT_ORDER 11
`define ACR_SLOT_FILTER 12
`define ACR_SLOT_GAIN 13
`define ACR_SLOT_UPPER 14

// ********************
// bit positions
// ********************
`define ACR_BIT_SOFT_RESET 0
`define ACR_BIT_READBACK 0
`define ACR_BIT_UNLOCK 4
`define ACR_BIT_SYNC_EN 13
`define ACR_BIT_LIGHT 8
`define ACR_BIT_DEEP 9
`define ACR_BIT_PIN_SEL 10
`define ACR_BIT_FRAME_EN 14
`define ACR_BIT_RAMP 6
`define ACR_BIT_TWO 5
`define ACR_BIT_ONE 4
`define ACR_BIT_SOFT_ALIGN 8
`define ACR_BIT_RANDOM 12
`define ACR_BIT_SHORT 13
`define ACR_BIT_SEED_SRC 14
`define ACR_BIT_PIN_ALIGN 15
`define ACR_BIT_FAMILY 15
`define ACR_BIT_INTERLEAVE 8
`define ACR_BIT_FILTER 1
`define ACR_BIT_AVG 0

`endif

/* File: rtl/acr_pkg.sv */
package acr_pkg;
    typedef logic [15:0] acr_word_t;
    typedef logic [7:0] acr_addr_t;
    typedef logic [23:0] acr_frame_t;
    typedef logic [13:0] acr_code_t;
    typedef enum logic [2:0] {
        ACR_PAT_NONE,
        ACR_PAT_RAMP,
        ACR_PAT_TWO_CODE,
        ACR_PAT_ONE_CODE,
        ACR_PAT_RANDOM
    } acr_pattern_t;
endpackage

/* File: rtl/acr_link_if.sv */
`timescale 1ns/1ns
interface acr_link_if;
    import acr_pkg::*;
    acr_frame_t frame_word;
    logic frame_tgl;
    acr_addr_t rd_addr;
    acr_word_t rd_data;
    logic readback_mode;
    modport link (
        output frame_word,
        output frame_tgl,
        output rd_addr,
        input rd_data,
        input readback_mode
    );
    modport bank (
        input frame_word,
        input frame_tgl,
        input rd_addr,
        output rd_data,
        output readback_mode
    );
endinterface

/* File: rtl/acr_serial_link.sv */
`timescale 1ns/1ns
`include "acr_cfg.svh"
module acr_serial_link #(
    parameter int FRAME_BITS = `ACR_FRAME_BITS
) (
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_input_pin,
    input wire logic sys_rst,
    acr_link_if.link lnk,
    output logic serial_readback_pin,
    output logic serial_readback_oe
);
    import acr_pkg::*;

    initial begin
        if (FRAME_BITS != `ACR_ADDR_BITS + `ACR_DATA_BITS) begin
            $error("frame length must equal address plus data bits");
        end
    end

    // ********************
    // frame capture on rising serial clock
    // ********************
    logic [4:0] bit_cnt;
    logic [22:0] shift_in;
    logic rb_meta;
    logic rb_sync;
    logic [15:0] shift_out;
    wire logic frame_rst = sys_rst | chip_select_n;
    wire logic frame_last = (bit_cnt == `ACR_CNT_FRAME_LAST);
    wire logic addr_last = (bit_cnt == `ACR_CNT_ADDR_LAST);
    wire logic read_load = (bit_cnt == `ACR_CNT_READ_LOAD);

    // counter cleared by the frame's own select, so partial words die
    always_ff @(posedge serial_clock or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt <= `ACR_CNT_ZERO;
        end else begin
            bit_cnt <= frame_last ? `ACR_CNT_ZERO : bit_cnt + 5'h01;
        end
    end

    always_ff @(posedge serial_clock or posedge sys_rst) begin
        if (sys_rst) begin
            shift_in <= 23'h000000;
        end else begin
            shift_in <= {shift_in[21:0], serial_input_pin};
        end
    end

    // word stays put long after the toggle, bank reads it once synced
    always_ff @(posedge serial_clock or posedge sys_rst) begin
        if (sys_rst) begin
            lnk.frame_word <= 24'h000000;
            lnk.frame_tgl <= 1'b0;
        end else if (frame_last) begin
            lnk.frame_word <= {shift_in, serial_input_pin};
            lnk.frame_tgl <= ~lnk.frame_tgl;
        end
    end

    always_ff @(posedge serial_clock or posedge sys_rst) begin
        if (sys_rst) begin
            lnk.rd_addr <= 8'h00;
        end else if (addr_last) begin
            lnk.rd_addr <= {shift_in[6:0], serial_input_pin};
        end
    end

    always_ff @(posedge serial_clock or posedge sys_rst) begin
        if (sys_rst) begin
            rb_meta <= 1'b0;
            rb_sync <= 1'b0;
        end else begin
            rb_meta <= lnk.readback_mode;
            rb_sync <= rb_meta;
        end
    end

    // ********************
    // readback shift on falling serial clock
    // ********************
    // register contents are frozen in readback, so the mux is quasi-static
    always_ff @(negedge serial_clock or posedge sys_rst) begin
        if (sys_rst) begin
            shift_out <= `ACR_RESET_WORD;
        end else if (!rb_sync) begin
            shift_out <= `ACR_RESET_WORD;
        end else if (read_load) begin
            shift_out <= lnk.rd_data;
        end else begin
            shift_out <= {shift_out[14:0], 1'b0};
        end
    end

    assign serial_readback_pin = shift_out[15];
    assign serial_readback_oe = rb_sync;
endmodule

/* File: rtl/acr_register_bank.sv */
// Notes on behaviour
// - writing one to bit 0 of address 00 clears all registers; bit reads zero
// - bit 0 of address 01 turns readback mode on or off
// - bit 4 of address 01 unlocks access to address F0
// - address 0A holds the ramp restart value, all 16 bits
// - bits 7..0 of address 0F put channels 8..1 to sleep
// - bit 8 of 0F selects light sleep, bit 9 deep sleep
// - bit 10 of 0F makes the sleep pin light, else deep
// - bits 7..0 of address 14 enable noise suppression, channels 8..1
// - bit 14 of 1C makes frame clock follow bits 13..0
// - 23-bit seed from 23 and 24[15:9], used when 25[14] set
// - bits 7..0 of address 24 invert input polarity, channels 8..1
// - 25 bits 6,5,4 pick ramp, two-code, one-code; only one set
// - custom codes are 14 bits, top bits in 25, low in 26/27
// - 25 bit 8 is the soft alignment trigger for all channels
// - 25 bit 15 enables alignment from the external sync pin
// - 25 bit 12 enables random pattern, bit 13 selects short generator
// - with 28[15] low, bit 8 picks odd/even or upper/lower split
// - with 28[15] high, bits 7..0 alternate samples across two wires
// - 29 bit 1 enables filters, bit 0 enables averaging
// - address 2A holds four 4-bit gains, channel 1 lowest
// - frames are 24 bits on rising clock with select low, address first
// - in readback only address 01 is writable; it never reads back
// - readback shifts 16 bits out msb first; pin floats otherwise
`timescale 1ns/1ns
`include "acr_cfg.svh"
module acr_register_bank (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_input_pin,
    output logic serial_readback_pin,
    output logic serial_readback_oe,
    output logic readback_mode,
    output logic upper_address_unlock,
    output acr_pkg::acr_word_t upper_page_word,
    output logic pattern_sync_enable,
    output acr_pkg::acr_word_t ramp_restart_value,
    output logic [7:0] channel_sleep_bits,
    output logic light_sleep,
    output logic deep_sleep,
    output logic sleep_pin_select,
    output logic [7:0] noise_suppress_bits,
    output logic frame_pattern_enable,
    output acr_pkg::acr_code_t frame_pattern_bits,
    output logic [22:0] random_seed,
    output logic seed_source_select,
    output logic [7:0] input_invert_bits,
    output logic ramp_select,
    output logic two_code_select,
    output logic one_code_select,
    output acr_pkg::acr_pattern_t pattern_mode,
    output acr_pkg::acr_code_t first_custom_code,
    output acr_pkg::acr_code_t second_custom_code,
    output logic pattern_soft_align,
    output logic pattern_pin_align,
    output logic random_pattern_enable,
    output logic short_lfsr_select,
    output logic order_family_select,
    output logic odd_even_split,
    output logic [7:0] alternate_sample_bits,
    output logic filter_enable,
    output logic averaging_enable,
    output logic [3:0] gain_first_channel,
    output logic [3:0] gain_second_channel,
    output logic [3:0] gain_third_channel,
    output logic [3:0] gain_fourth_channel
);
    import acr_pkg::*;

    // ********************
    // slot map
    // ********************
    localparam int NUM_SLOTS = `ACR_NUM_SLOTS;
    localparam acr_addr_t SLOT_ADDR [NUM_SLOTS] = '{
        `ACR_ADDR_READBACK,
        `ACR_ADDR_SYNC,
        `ACR_ADDR_RAMP,
        `ACR_ADDR_POWER,
        `ACR_ADDR_NOISE,
        `ACR_ADDR_FRAME,
        `ACR_ADDR_SEED_LO,
        `ACR_ADDR_INV_SEED,
        `ACR_ADDR_TEST,
        `ACR_ADDR_CODE1,
        `ACR_ADDR_CODE2,
        `ACR_ADDR_ORDER,
        `ACR_ADDR_FILTER,
        `ACR_ADDR_GAIN,
        `ACR_ADDR_UPPER
    };
    // unused bits never store, so they read back as zero
    localparam acr_word_t SLOT_MASK [NUM_SLOTS] = '{
        `ACR_MASK_READBACK,
        `ACR_MASK_SYNC,
        `ACR_MASK_FULL,
        `ACR_MASK_POWER,
        `ACR_MASK_NOISE,
        `ACR_MASK_FRAME,
        `ACR_MASK_FULL,
        `ACR_MASK_INV_SEED,
        `ACR_MASK_TEST,
        `ACR_MASK_CODE,
        `ACR_MASK_CODE,
        `ACR_MASK_ORDER,
        `ACR_MASK_FILTER,
        `ACR_MASK_FULL,
        `ACR_MASK_FULL
    };

    // ********************
    // serial side
    // ********************
    acr_link_if lnk ();

    acr_serial_link #(
        .FRAME_BITS(`ACR_FRAME_BITS)
    ) u_link (
        .serial_clock(serial_clock),
        .chip_select_n(chip_select_n),
        .serial_input_pin(serial_input_pin),
        .sys_rst(sys_rst),
        .lnk(lnk.link),
        .serial_readback_pin(serial_readback_pin),
        .serial_readback_oe(serial_readback_oe)
    );

    // ********************
    // frame toggle crossing
    // ********************
    logic tgl_meta;
    logic tgl_sync;
    logic tgl_seen;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_meta <= 1'b0;
            tgl_sync <= 1'b0;
            tgl_seen <= 1'b0;
        end else begin
            tgl_meta <= lnk.frame_tgl;
            tgl_sync <= tgl_meta;
            tgl_seen <= tgl_sync;
        end
    end

    // ********************
    // write decode
    // ********************
    acr_word_t cfg [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] slot_we;

    wire logic frame_arrived = tgl_sync ^ tgl_seen;
    wire acr_addr_t wr_addr = lnk.frame_word[`ACR_ADDR_LSB +: `ACR_ADDR_BITS];
    wire acr_word_t wr_data = lnk.frame_word[`ACR_DATA_BITS-1:0];
    wire logic wr_is_readback = (wr_addr == `ACR_ADDR_READBACK);
    wire logic write_ok = frame_arrived & (~readback_mode | wr_is_readback);
    wire logic soft_reset = write_ok & (wr_addr == `ACR_ADDR_SOFT_RESET)
        & wr_data[`ACR_BIT_SOFT_RESET];

    // ********************
    // storage
    // ********************
    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : gen_slot
            // upper page only reachable once unlocked
            if (g == `ACR_SLOT_UPPER) begin : gen_gated
                assign slot_we[g] = write_ok & (wr_addr == SLOT_ADDR[g])
                    & upper_address_unlock;
            end else begin : gen_open
                assign slot_we[g] = write_ok & (wr_addr == SLOT_ADDR[g]);
            end

            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    cfg[g] <= `ACR_RESET_WORD;
                end else if (soft_reset) begin
                    cfg[g] <= `ACR_RESET_WORD;
                end else if (slot_we[g]) begin
                    cfg[g] <= wr_data & SLOT_MASK[g];
                end
            end
        end
    endgenerate

    // ********************
    // readback mux
    // ********************
    acr_word_t rd_word;

    // address 01 and a locked upper page read as zero
    always_comb begin
        rd_word = `ACR_RESET_WORD;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (lnk.rd_addr == SLOT_ADDR[i] && i != `ACR_SLOT_READBACK
                && (i != `ACR_SLOT_UPPER || upper_address_unlock)) begin
                rd_word = cfg[i];
            end
        end
    end

    assign lnk.rd_data = rd_word;
    assign lnk.readback_mode = readback_mode;

    // ********************
    // readback and unlock control
    // ********************
    wire acr_word_t reg_readback = cfg[`ACR_SLOT_READBACK];
    assign readback_mode = reg_readback[`ACR_BIT_READBACK];
    assign upper_address_unlock = reg_readback[`ACR_BIT_UNLOCK];
    assign upper_page_word = cfg[`ACR_SLOT_UPPER];

    // ********************
    // pattern alignment
    // ********************
    wire acr_word_t reg_sync = cfg[`ACR_SLOT_SYNC];
    wire acr_word_t reg_test = cfg[`ACR_SLOT_TEST];
    assign pattern_sync_enable = reg_sync[`ACR_BIT_SYNC_EN];
    // alignment stays off unless the sync enable is also set
    assign pattern_soft_align = pattern_sync_enable
        & reg_test[`ACR_BIT_SOFT_ALIGN];
    assign pattern_pin_align = pattern_sync_enable
        & reg_test[`ACR_BIT_PIN_ALIGN];

    // ********************
    // ramp value
    // ********************
    assign ramp_restart_value = cfg[`ACR_SLOT_RAMP];

    // ********************
    // power down
    // ********************
    wire acr_word_t reg_power = cfg[`ACR_SLOT_POWER];
    assign channel_sleep_bits = reg_power[7:0];
    assign light_sleep = reg_power[`ACR_BIT_LIGHT];
    assign deep_sleep = reg_power[`ACR_BIT_DEEP];
    assign sleep_pin_select = reg_power[`ACR_BIT_PIN_SEL];

    // ********************
    // noise suppression and input polarity
    // ********************
    wire acr_word_t reg_noise = cfg[`ACR_SLOT_NOISE];
    wire acr_word_t reg_inv_seed = cfg[`ACR_SLOT_INV_SEED];
    assign noise_suppress_bits = reg_noise[7:0];
    assign input_invert_bits = reg_inv_seed[7:0];

    // ********************
    // frame clock pattern
    // ********************
    wire acr_word_t reg_frame = cfg[`ACR_SLOT_FRAME];
    assign frame_pattern_enable = reg_frame[`ACR_BIT_FRAME_EN];
    assign frame_pattern_bits = reg_frame[13:0];

    // ********************
    // random pattern
    // ********************
    assign random_seed = {reg_inv_seed[15:9], cfg[`ACR_SLOT_SEED_LO]};
    assign seed_source_select = reg_test[`ACR_BIT_SEED_SRC];
    assign random_pattern_enable = reg_test[`ACR_BIT_RANDOM];
    assign short_lfsr_select = reg_test[`ACR_BIT_SHORT];

    // ********************
    // custom and ramp patterns
    // ********************
    wire acr_word_t reg_code1 = cfg[`ACR_SLOT_CODE1];
    wire acr_word_t reg_code2 = cfg[`ACR_SLOT_CODE2];
    assign ramp_select = reg_test[`ACR_BIT_RAMP];
    assign two_code_select = reg_test[`ACR_BIT_TWO];
    assign one_code_select = reg_test[`ACR_BIT_ONE];
    assign first_custom_code = {reg_test[1:0], reg_code1[15:4]};
    assign second_custom_code = {reg_test[3:2], reg_code2[15:4]};

    // fixed priority keeps a single mode if software sets several
    always_comb begin
        if (random_pattern_enable) begin
            pattern_mode = ACR_PAT_RANDOM;
        end else if (ramp_select) begin
            pattern_mode = ACR_PAT_RAMP;
        end else if (two_code_select) begin
            pattern_mode = ACR_PAT_TWO_CODE;
        end else if (one_code_select) begin
            pattern_mode = ACR_PAT_ONE_CODE;
        end else begin
            pattern_mode = ACR_PAT_NONE;
        end
    end

    // ********************
    // output bit order
    // ********************
    wire acr_word_t reg_order = cfg[`ACR_SLOT_ORDER];
    assign order_family_select = reg_order[`ACR_BIT_FAMILY];
    assign odd_even_split = ~order_family_select
        & reg_order[`ACR_BIT_INTERLEAVE];
    assign alternate_sample_bits = order_family_select ? reg_order[7:0]
        : 8'h00;

    // ********************
    // filters, averaging and gain
    // ********************
    wire acr_word_t reg_filter = cfg[`ACR_SLOT_FILTER];
    wire acr_word_t reg_gain = cfg[`ACR_SLOT_GAIN];
    assign filter_enable = reg_filter[`ACR_BIT_FILTER];
    assign averaging_enable = reg_filter[`ACR_BIT_AVG];
    assign gain_first_channel = reg_gain[3:0];
    assign gain_second_channel = reg_gain[7:4];
    assign gain_third_channel = reg_gain[11:8];
    assign gain_fourth_channel = reg_gain[15:12];
endmodule

/* File: testbench/acr_register_bank_sva.sv */
`timescale 1ns/1ns
module acr_register_bank_sva (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic serial_clock,
    input wire logic serial_readback_pin,
    input wire logic serial_readback_oe,
    input wire logic readback_mode,
    input wire logic pattern_sync_enable,
    input wire logic pattern_soft_align,
    input wire logic pattern_pin_align,
    input wire logic random_pattern_enable,
    input wire logic ramp_select,
    input wire acr_pkg::acr_pattern_t pattern_mode,
    input wire logic order_family_select,
    input wire logic odd_even_split,
    input wire logic [7:0] alternate_sample_bits
);
    import acr_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // readback off, seen on three link edges
    sequence seq_rb_off;
        !readback_mode [*3];
    endsequence
    // enable reaches the link side within the synchroniser delay
    sequence seq_oe_up;
        ##[1:3] serial_readback_oe;
    endsequence
    AST_RESET_CLEAR: assert property ($fell(sys_rst) |-> pattern_mode == ACR_PAT_NONE
        && !readback_mode && !serial_readback_oe && !pattern_sync_enable)
        else $error("outputs not clear after reset");
    AST_SOFT_ALIGN: assert property (pattern_soft_align |-> pattern_sync_enable)
        else $error("soft align without sync enable");
    AST_PIN_ALIGN: assert property (pattern_pin_align |-> pattern_sync_enable)
        else $error("pin align without sync enable");
    AST_RANDOM_MODE: assert property (random_pattern_enable
        |-> pattern_mode == ACR_PAT_RANDOM) else $error("random enable not in mode");
    AST_RAMP_MODE: assert property (ramp_select && !random_pattern_enable
        |-> pattern_mode == ACR_PAT_RAMP) else $error("ramp select not in mode");
    AST_SPLIT_FAMILY: assert property (odd_even_split |-> !order_family_select)
        else $error("split active in word family");
    AST_WORD_FAMILY: assert property (!order_family_select
        |-> alternate_sample_bits == 8'h00) else $error("alternate bits outside word family");
    AST_OE_FOLLOW: assert property (@(posedge serial_clock) disable iff (sys_rst)
        $rose(readback_mode) |-> seq_oe_up) else $error("readback enable late");
    AST_PIN_QUIET: assert property (@(posedge serial_clock) disable iff (sys_rst)
        seq_rb_off |-> !serial_readback_oe && !serial_readback_pin) else $error("pin not quiet");
endmodule
bind acr_register_bank acr_register_bank_sva i_sva (.clock, .sys_rst, .serial_clock,
    .serial_readback_pin, .serial_readback_oe, .readback_mode, .pattern_sync_enable,
    .pattern_soft_align, .pattern_pin_align, .random_pattern_enable, .ramp_select,
    .pattern_mode, .order_family_select, .odd_even_split, .alternate_sample_bits);

/* File: testbench/acr_ctl_model.sv */
`timescale 1ns/1ns
module acr_ctl_model (
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_input_pin,
    input wire logic serial_readback_pin
);
    initial begin
        serial_clock = 1'b0;
        chip_select_n = 1'b1;
        serial_input_pin = 1'b0;
    end
    // one 24-bit word per select, clock still outside frames
    task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        logic [23:0] w;
        w = {a, d};
        q = 16'h0000;
        #3 chip_select_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            serial_input_pin = w[i];
            #16 serial_clock = 1'b1;
            q = {q[14:0], serial_readback_pin};
            #16 serial_clock = 1'b0;
        end
        #16 chip_select_n = 1'b1;
        serial_input_pin = ~serial_input_pin;
    endtask
endmodule

/* File: testbench/acr_register_bank_tb.sv */
`timescale 1ns/1ns
module acr_register_bank_tb;
    import acr_pkg::*;
    localparam logic [7:0] reg_list [12] = '{8'h0A, 8'h0F, 8'h14, 8'h1C, 8'h23, 8'h24,
        8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A};
    logic clock;
    logic sys_rst;
    wire logic serial_clock;
    wire logic chip_select_n;
    wire logic serial_input_pin;
    wire logic serial_readback_pin;
    logic [15:0] sh [256];
    logic [15:0] q;
    logic [15:0] d;
    int mismatches;
    int checks_done;
    int cycles;
    acr_ctl_model i_ctl (.serial_clock, .chip_select_n, .serial_input_pin,
        .serial_readback_pin);
    acr_register_bank i_dut (.clock(clock), .sys_rst(sys_rst), .serial_clock(serial_clock),
        .chip_select_n(chip_select_n), .serial_input_pin(serial_input_pin),
        .serial_readback_pin(serial_readback_pin), .serial_readback_oe(), .readback_mode(),
        .upper_address_unlock(), .upper_page_word(), .pattern_sync_enable(),
        .ramp_restart_value(), .channel_sleep_bits(), .light_sleep(), .deep_sleep(),
        .sleep_pin_select(), .noise_suppress_bits(), .frame_pattern_enable(),
        .frame_pattern_bits(), .random_seed(), .seed_source_select(), .input_invert_bits(),
        .ramp_select(), .two_code_select(), .one_code_select(), .pattern_mode(),
        .first_custom_code(), .second_custom_code(), .pattern_soft_align(),
        .pattern_pin_align(), .random_pattern_enable(), .short_lfsr_select(),
        .order_family_select(), .odd_even_split(), .alternate_sample_bits(),
        .filter_enable(), .averaging_enable(), .gain_first_channel(),
        .gain_second_channel(), .gain_third_channel(), .gain_fourth_channel());
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    function automatic logic [15:0] mask_of(input logic [7:0] a);
        case (a)
            8'h0F: return 16'h07FF;
            8'h14: return 16'h00FF;
            8'h1C: return 16'h7FFF;
            8'h24: return 16'hFEFF;
            8'h25: return 16'hF17F;
            8'h26, 8'h27: return 16'hFFF0;
            8'h28: return 16'h81FF;
            8'h29: return 16'h0003;
            default: return 16'hFFFF;
        endcase
    endfunction
    function automatic acr_pattern_t mode_of(input logic [15:0] t);
        if (t[12]) return ACR_PAT_RANDOM;
        if (t[6]) return ACR_PAT_RAMP;
        if (t[5]) return ACR_PAT_TWO_CODE;
        if (t[4]) return ACR_PAT_ONE_CODE;
        return ACR_PAT_NONE;
    endfunction
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clock);
        #1;
        i_ctl.xfer(a, v, q);
    endtask
    task automatic check_ports();
        chk(i_dut.ramp_restart_value === sh[8'h0A], "ramp");
        chk({i_dut.sleep_pin_select, i_dut.deep_sleep, i_dut.light_sleep,
            i_dut.channel_sleep_bits} === sh[8'h0F][10:0], "sleep");
        chk(i_dut.noise_suppress_bits === sh[8'h14][7:0], "noise");
        chk({i_dut.frame_pattern_enable, i_dut.frame_pattern_bits}
            === sh[8'h1C][14:0], "frm");
        chk({i_dut.seed_source_select, i_dut.random_seed}
            === {sh[8'h25][14], sh[8'h24][15:9], sh[8'h23]}, "seed");
        chk(i_dut.input_invert_bits === sh[8'h24][7:0], "invert");
        chk(i_dut.pattern_mode === mode_of(sh[8'h25]), "mode");
        chk({i_dut.first_custom_code, i_dut.second_custom_code} === {sh[8'h25][1:0],
            sh[8'h26][15:4], sh[8'h25][3:2], sh[8'h27][15:4]}, "codes");
        chk({i_dut.pattern_soft_align, i_dut.pattern_pin_align, i_dut.random_pattern_enable,
            i_dut.short_lfsr_select, i_dut.ramp_select, i_dut.two_code_select,
            i_dut.one_code_select} === {sh[8'h02][13] & sh[8'h25][8], sh[8'h02][13]
            & sh[8'h25][15], sh[8'h25][12], sh[8'h25][13], sh[8'h25][6:4]}, "pat");
        chk({i_dut.order_family_select, i_dut.odd_even_split, i_dut.alternate_sample_bits}
            === {sh[8'h28][15], ~sh[8'h28][15] & sh[8'h28][8],
            sh[8'h28][15] ? sh[8'h28][7:0] : 8'h00}, "order");
        chk({i_dut.filter_enable, i_dut.averaging_enable} === sh[8'h29][1:0], "filt");
        chk({i_dut.gain_fourth_channel, i_dut.gain_third_channel, i_dut.gain_second_channel,
            i_dut.gain_first_channel} === sh[8'h2A], "gain");
        chk(i_dut.readback_mode === sh[8'h01][0], "rbmode");
    endtask
    task automatic finish_test();
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            $display("BAD %0t timeout", $time);
            finish_test();
        end
    end
    initial begin
        sys_rst = 1'b1;
        d = $urandom(32'h6EAC);
        foreach (sh[i]) sh[i] = 16'h0000;
        repeat (3) @(posedge clock);
        #1 sys_rst = 1'b0;
        repeat (3) @(posedge clock);
        check_ports();
        wr(8'h02, 16'h2000);
        sh[8'h02] = 16'h2000;
        for (int n = 0; n < 4; n++) begin
            foreach (reg_list[k]) begin
                d = 16'($urandom()) & mask_of(reg_list[k]);
                if (reg_list[k] == 8'h25) begin
                    d[6:4] = 3'(3'b001 << n);
                    d[15] = n[0];
                    d[12] = (n == 3);
                    d[8] = ~n[0];
                end
                if (reg_list[k] == 8'h28) d[15:8] = {n[0], 6'h00, n[1]};
                wr(reg_list[k], d);
                sh[reg_list[k]] = d;
            end
            check_ports();
        end
        wr(8'h01, 16'h0001);
        sh[8'h01] = 16'h0001;
        foreach (reg_list[k]) begin
            wr(reg_list[k], 16'h0000);
            chk(q === sh[reg_list[k]], "readback");
        end
        wr(8'h0A, ~sh[8'h0A]);
        wr(8'h01, 16'h0000);
        chk(q === 16'h0000, "rb addr 01");
        sh[8'h01] = 16'h0000;
        check_ports();
        wr(8'hF0, 16'hA5C3);
        chk(i_dut.upper_page_word === 16'h0000, "locked page");
        wr(8'h01, 16'h0010);
        wr(8'hF0, 16'hA5C3);
        chk(i_dut.upper_page_word === 16'hA5C3, "open page");
        wr(8'h00, 16'h0001);
        foreach (sh[i]) sh[i] = 16'h0000;
        check_ports();
        chk({i_dut.upper_address_unlock, i_dut.upper_page_word} === 17'h00000, "soft");
        finish_test();
    end
endmodule
